// file: shared/csp_cfg.svh
// Constants of the console serial port: register offsets, fields, reset values,
// character codes and timing. Definitions only; included by bare name.
`ifndef CSP_CFG_SVH
`define CSP_CFG_SVH

`define CSP_CLK_HZ 20000000
`define CSP_BAUD_A 2400
`define CSP_BAUD_B 1200
`define CSP_BAUD_C 600
`define CSP_BAUD_D 300
`define CSP_BAUD_E 150
`define CSP_BAUD_F 110

`define CSP_REG_CTRL 5'h00
`define CSP_REG_STATUS 5'h04
`define CSP_REG_RXDATA 5'h08
`define CSP_REG_TXDATA 5'h0C
`define CSP_REG_IRQ_STAT 5'h10
`define CSP_REG_IRQ_CLR 5'h14
`define CSP_REG_IRQ_EN 5'h18

`define CSP_CTRL_ASCII 0
`define CSP_CTRL_FILL_LO 1
`define CSP_CTRL_READER 3
`define CSP_CTRL_XOFF_LO 8
`define CSP_CTRL_RESET 16'h1300

`define CSP_CH_NUL 8'h00
`define CSP_CH_BS 8'h08
`define CSP_CH_LF 8'h0A
`define CSP_CH_CR 8'h0D
`define CSP_CH_XON 8'h11
`define CSP_CH_XOF 8'h13
`define CSP_CH_CTRLZ 8'h1A
`define CSP_CH_ESC 8'h1B
`define CSP_CH_DEL 8'h7F

`define CSP_ECHO_FILLS 3'h3
`define CSP_DEFAULT_FILLS 3'h4
`define CSP_LINE_DEPTH 5'h10
`define CSP_RTS_LIMIT 5'h0E

`endif

// file: shared/csp_pkg.sv
// Types shared by the console serial port design.
// Assumes csp_cfg.svh for numeric constants.
package csp_pkg;
  typedef logic [7:0] csp_char_t;
  typedef enum logic [2:0] {SQ_IDLE, SQ_LEAD, SQ_LF, SQ_XOFF, SQ_FILL} csp_seq_e;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} csp_rx_e;
  typedef enum logic {TX_IDLE, TX_SHIFT} csp_tx_e;
endpackage

// file: logic/csp_top.sv
// Console serial port: UART with thumbwheel baud select, format strap, modem
// handshake, line-edit receive handling and line-end expansion on transmit.
// Assumes an Avalon-MM master on clk and asynchronous pins from the terminal.
//
// How it works
// RULE1: Positions 3..7 run 2400..150 baud, start, seven data, parity, one stop; the code sends eight data bits there unless ascii_mode is set.
// RULE2: Positions 8 and 9 run 110 baud with two stop bits.
// RULE3: Positions 0, 1 and 2 are unused; the link stays idle.
// RULE4: At 110 baud software may pick binary or ASCII format.
// RULE5: Without the format strap every baud rate uses binary format.
// RULE6: Terminal ready, clear to send and set ready gate sending; request to send out.
// RULE7: A full line buffer drops request to send; sender waits for clear to send.
// RULE8: Received CR or ESC echoes CR LF XOF three nulls; sets end of line, ESC break.
// RULE9: Received backspace echoes backspace and drops the last buffered character.
// RULE10: Received delete echoes delete and drops the last buffered character.
// RULE11: Sent CR is followed by LF, the transmitter-off code and nulls; code 00 omits it.
// RULE12: Null fill count after a sent line end can be cut by 0 to 3.
// RULE13: Four null fills are sent after a line end by default.
// RULE14: Tape reader input gets the same control character handling as keyboard input.
// RULE15: A tape reader read turns the reader control on and sends transmitter-on.
// RULE16: Stop bits beyond the first are accepted and ignored.
// RULE17: The bit clock divides the board clock by a count picked by the selector.
//
// The register offsets and the Avalon-MM register port were chosen for this implementation.
`include "csp_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module csp_top
  import csp_pkg::*;
#(
  parameter int unsigned BIT_CYC_A = `CSP_CLK_HZ / `CSP_BAUD_A,
  parameter int unsigned BIT_CYC_B = `CSP_CLK_HZ / `CSP_BAUD_B,
  parameter int unsigned BIT_CYC_C = `CSP_CLK_HZ / `CSP_BAUD_C,
  parameter int unsigned BIT_CYC_D = `CSP_CLK_HZ / `CSP_BAUD_D,
  parameter int unsigned BIT_CYC_E = `CSP_CLK_HZ / `CSP_BAUD_E,
  parameter int unsigned BIT_CYC_F = `CSP_CLK_HZ / `CSP_BAUD_F
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  input wire logic [3:0] baud_sel,
  input wire logic binary_format_strap,
  input wire logic rxd,
  output logic txd,
  output logic rts,
  input wire logic cts,
  input wire logic dsr,
  input wire logic dtr,
  output logic reader_control_out
);

  logic [1:0] rst_sync_reg;
  logic rst_n;
  logic [8:0] in_meta_reg;
  logic [8:0] in_sync_reg;
  logic [3:0] sel;
  logic strap_fitted;
  logic rxd_s;
  logic hs_ok;
  logic baud_ok;
  logic two_stop;
  logic ascii_mode;

  // Reset release through two stages
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rst_sync_reg <= 2'h0;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  // Selector, strap and terminal pins are asynchronous, so each of the nine bits passes two stages
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      in_meta_reg <= 9'h1FF;
      in_sync_reg <= 9'h1FF;
    end
    else
    begin
      in_meta_reg <= {baud_sel, binary_format_strap, rxd, cts, dsr, dtr};
      in_sync_reg <= in_meta_reg;
    end
  end
  assign sel = in_sync_reg[8:5];
  assign strap_fitted = in_sync_reg[4];
  assign rxd_s = in_sync_reg[3];
  assign hs_ok = in_sync_reg[2] & in_sync_reg[1] & in_sync_reg[0]; // see RULE6

  function automatic logic [17:0] bit_cycles(input logic [3:0] s);
    case (s)
      4'h3: bit_cycles = BIT_CYC_A[17:0]; // see RULE1
      4'h4: bit_cycles = BIT_CYC_B[17:0];
      4'h5: bit_cycles = BIT_CYC_C[17:0];
      4'h6: bit_cycles = BIT_CYC_D[17:0];
      4'h7: bit_cycles = BIT_CYC_E[17:0];
      4'h8, 4'h9: bit_cycles = BIT_CYC_F[17:0]; // see RULE2
      default: bit_cycles = 18'h00000; // see RULE3
    endcase
  endfunction

  function automatic logic even_parity(input logic [6:0] d);
    even_parity = ^d;
  endfunction

  logic [15:0] ctrl_reg;
  assign baud_ok = bit_cycles(sel) != 18'h00000; // see RULE17
  assign two_stop = sel >= 4'h8; // see RULE2
  // ASCII only with the strap fitted; strap absent forces binary
  assign ascii_mode = strap_fitted & ctrl_reg[`CSP_CTRL_ASCII]; // see RULE4 see RULE5

  // Receiver
  csp_rx_e rx_state;
  logic [17:0] rx_cnt;
  logic [17:0] rx_len;
  logic [2:0] rx_bits;
  logic [7:0] rx_shift;
  logic rx_done;
  logic rx_ferr;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_state <= RX_IDLE;
      rx_cnt <= 18'h00000;
      rx_len <= 18'h00000;
      rx_bits <= 3'h0;
      rx_shift <= 8'h00;
      rx_done <= 1'b0;
      rx_ferr <= 1'b0;
    end
    else
    begin
      rx_done <= 1'b0;
      rx_ferr <= 1'b0;
      case (rx_state)
        RX_IDLE:
          if (baud_ok && !rxd_s)
          begin
            rx_len <= bit_cycles(sel); // see RULE17
            rx_cnt <= bit_cycles(sel) >> 1;
            rx_state <= RX_START;
          end
        RX_START:
          if (rx_cnt == 18'h00000)
          begin
            rx_cnt <= rx_len - 18'h00001;
            rx_bits <= 3'h0;
            rx_state <= rxd_s ? RX_IDLE : RX_DATA;
          end
          else
            rx_cnt <= rx_cnt - 18'h00001;
        RX_DATA:
          if (rx_cnt == 18'h00000)
          begin
            rx_shift <= {rxd_s, rx_shift[7:1]};
            rx_bits <= rx_bits + 3'h1;
            rx_cnt <= rx_len - 18'h00001;
            if (rx_bits == 3'h7)
              rx_state <= RX_STOP;
          end
          else
            rx_cnt <= rx_cnt - 18'h00001;
        default:
          if (rx_cnt == 18'h00000)
          begin
            // Only the first stop is checked; later ones read as idle line
            rx_done <= rxd_s; // see RULE16
            rx_ferr <= !rxd_s;
            rx_state <= RX_IDLE;
          end
          else
            rx_cnt <= rx_cnt - 18'h00001;
      endcase
    end
  end

  // Bus handshake terms
  logic wr_acc;
  logic rd_acc;
  logic sw_pend;
  assign wr_acc = avs_write & !avs_waitrequest;
  assign rd_acc = avs_read & !avs_waitrequest;

  // Line buffer and receive character handling
  logic [7:0] line_mem [0:15];
  logic [4:0] wr_ptr;
  logic [4:0] rd_ptr;
  logic [4:0] line_cnt;
  logic pop;
  logic [4:0] ev_rx;
  logic echo_req;
  logic echo_exp;
  csp_char_t echo_code;
  csp_char_t rx_ch;
  logic [4:0] keep_min;
  assign line_cnt = wr_ptr - rd_ptr;
  assign pop = rd_acc && avs_address == `CSP_REG_RXDATA && line_cnt != 5'h00;
  assign rx_ch = ascii_mode ? {1'b0, rx_shift[6:0]} : rx_shift;
  assign keep_min = pop ? 5'h01 : 5'h00;

  // Keyboard and tape reader share this path, so edits apply alike
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr <= 5'h00;
      ev_rx <= 5'h00;
      echo_req <= 1'b0;
      echo_exp <= 1'b0;
      echo_code <= 8'h00;
    end
    else
    begin
      ev_rx <= {rx_ferr, 4'h0};
      echo_req <= 1'b0;
      if (rx_done)
      begin
        if (!ascii_mode)
        begin
          if (line_cnt < `CSP_LINE_DEPTH)
          begin
            line_mem[wr_ptr[3:0]] <= rx_ch;
            wr_ptr <= wr_ptr + 5'h01;
            ev_rx[0] <= 1'b1;
          end
          else
            ev_rx[4] <= 1'b1;
        end
        else
        begin
          case (rx_ch) // see RULE14
            `CSP_CH_CR, `CSP_CH_ESC, `CSP_CH_CTRLZ:
            begin
              if (line_cnt < `CSP_LINE_DEPTH)
              begin
                line_mem[wr_ptr[3:0]] <= `CSP_CH_CR;
                wr_ptr <= wr_ptr + 5'h01;
              end
              else
                ev_rx[4] <= 1'b1;
              ev_rx[1] <= 1'b1; // see RULE8
              ev_rx[2] <= rx_ch == `CSP_CH_ESC;
              ev_rx[3] <= rx_ch == `CSP_CH_CTRLZ;
              echo_req <= rx_ch != `CSP_CH_CTRLZ;
              echo_exp <= 1'b1;
              echo_code <= `CSP_CH_CR;
            end
            `CSP_CH_BS, `CSP_CH_DEL:
            begin
              if (line_cnt > keep_min)
                wr_ptr <= wr_ptr - 5'h01; // see RULE9 see RULE10
              echo_req <= 1'b1;
              echo_exp <= 1'b0;
              echo_code <= rx_ch;
            end
            `CSP_CH_XOF:
            begin
              echo_req <= 1'b1;
              echo_exp <= 1'b0;
              echo_code <= `CSP_CH_XON;
            end
            `CSP_CH_LF, `CSP_CH_NUL:
              ev_rx[0] <= 1'b0;
            default:
              if (line_cnt < `CSP_LINE_DEPTH)
              begin
                line_mem[wr_ptr[3:0]] <= rx_ch;
                wr_ptr <= wr_ptr + 5'h01;
                ev_rx[0] <= 1'b1;
              end
              else
                ev_rx[4] <= 1'b1;
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_ptr <= 5'h00;
      rts <= 1'b0;
      reader_control_out <= 1'b0;
    end
    else
    begin
      if (pop)
        rd_ptr <= rd_ptr + 5'h01;
      rts <= line_cnt < `CSP_RTS_LIMIT; // see RULE7
      // Reader runs from a tape read until the next character lands
      if (pop && ctrl_reg[`CSP_CTRL_READER])
        reader_control_out <= 1'b1; // see RULE15
      else if (rx_done)
        reader_control_out <= 1'b0;
    end
  end

  // Transmit sequencer: echo first, then transmitter-on, then software data
  csp_seq_e seq_state;
  logic echo_pend;
  logic xon_pend;
  logic pend_exp;
  csp_char_t pend_code;
  csp_char_t sw_data;
  csp_char_t lead_ch;
  csp_char_t xoff_ch;
  logic seq_exp;
  logic [2:0] fill_left;
  logic tx_load;
  csp_char_t tx_byte;
  logic tx_ready;
  logic ev_txd;
  csp_tx_e tx_state;

  assign tx_ready = tx_state == TX_IDLE && !tx_load && hs_ok && baud_ok; // see RULE6 see RULE7

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      seq_state <= SQ_IDLE;
      echo_pend <= 1'b0;
      xon_pend <= 1'b0;
      sw_pend <= 1'b0;
      pend_exp <= 1'b0;
      pend_code <= 8'h00;
      sw_data <= 8'h00;
      lead_ch <= 8'h00;
      xoff_ch <= 8'h00;
      seq_exp <= 1'b0;
      fill_left <= 3'h0;
      tx_load <= 1'b0;
      tx_byte <= 8'h00;
      ev_txd <= 1'b0;
    end
    else
    begin
      tx_load <= 1'b0;
      ev_txd <= 1'b0;
      case (seq_state)
        SQ_IDLE:
          if (echo_pend)
          begin
            echo_pend <= 1'b0;
            lead_ch <= pend_code;
            seq_exp <= pend_exp;
            xoff_ch <= `CSP_CH_XOF;
            fill_left <= `CSP_ECHO_FILLS; // see RULE8
            seq_state <= SQ_LEAD;
          end
          else if (xon_pend)
          begin
            xon_pend <= 1'b0;
            lead_ch <= `CSP_CH_XON; // see RULE15
            seq_exp <= 1'b0;
            seq_state <= SQ_LEAD;
          end
          else if (sw_pend)
          begin
            sw_pend <= 1'b0;
            lead_ch <= sw_data;
            seq_exp <= ascii_mode && sw_data == `CSP_CH_CR; // see RULE11
            xoff_ch <= ctrl_reg[`CSP_CTRL_XOFF_LO +: 8];
            fill_left <= `CSP_DEFAULT_FILLS - {1'b0, ctrl_reg[`CSP_CTRL_FILL_LO +: 2]}; // see RULE12 see RULE13
            seq_state <= SQ_LEAD;
          end
        SQ_LEAD:
          if (tx_ready)
          begin
            tx_load <= 1'b1;
            tx_byte <= lead_ch;
            seq_state <= seq_exp ? SQ_LF : SQ_FILL;
            if (!seq_exp)
              fill_left <= 3'h0;
          end
        SQ_LF:
          if (tx_ready)
          begin
            tx_load <= 1'b1;
            tx_byte <= `CSP_CH_LF;
            seq_state <= SQ_XOFF;
          end
        SQ_XOFF:
          if (xoff_ch == 8'h00)
            seq_state <= SQ_FILL; // see RULE11
          else if (tx_ready)
          begin
            tx_load <= 1'b1;
            tx_byte <= xoff_ch;
            seq_state <= SQ_FILL;
          end
        default:
          if (fill_left == 3'h0)
          begin
            ev_txd <= 1'b1;
            seq_state <= SQ_IDLE;
          end
          else if (tx_ready)
          begin
            tx_load <= 1'b1;
            tx_byte <= `CSP_CH_NUL;
            fill_left <= fill_left - 3'h1;
          end
      endcase
      // Sets after clears so a request in the taking cycle survives
      if (echo_req)
      begin
        echo_pend <= 1'b1;
        pend_exp <= echo_exp;
        pend_code <= echo_code;
      end
      if (pop && ctrl_reg[`CSP_CTRL_READER])
        xon_pend <= 1'b1;
      if (wr_acc && avs_address == `CSP_REG_TXDATA)
      begin
        sw_pend <= 1'b1;
        sw_data <= avs_writedata[7:0];
      end
    end
  end

  // Transmit shifter; frame and bit length fixed at load
  logic [17:0] tx_cnt;
  logic [17:0] tx_len;
  logic [3:0] tx_left;
  logic [10:0] tx_shift;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_state <= TX_IDLE;
      tx_cnt <= 18'h00000;
      tx_len <= 18'h00000;
      tx_left <= 4'h0;
      tx_shift <= 11'h7FF;
      txd <= 1'b1;
    end
    else
    begin
      case (tx_state)
        TX_IDLE:
        begin
          txd <= 1'b1;
          if (tx_load)
          begin
            tx_len <= bit_cycles(sel);
            tx_cnt <= 18'h00000;
            tx_left <= two_stop ? 4'hB : 4'hA; // see RULE1 see RULE2
            if (ascii_mode)
              tx_shift <= {2'h3, even_parity(tx_byte[6:0]), tx_byte[6:0], 1'b0};
            else
              tx_shift <= {2'h3, tx_byte, 1'b0};
            tx_state <= TX_SHIFT;
          end
        end
        default:
          if (tx_cnt == 18'h00000)
          begin
            if (tx_left == 4'h0)
              tx_state <= TX_IDLE;
            else
            begin
              txd <= tx_shift[0];
              tx_shift <= {1'b1, tx_shift[10:1]};
              tx_left <= tx_left - 4'h1;
              tx_cnt <= tx_len - 18'h00001;
            end
          end
          else
            tx_cnt <= tx_cnt - 18'h00001;
      endcase
    end
  end

  // Register slave: one wait cycle; a TXDATA write waits longer while a transmit byte is queued
  logic [5:0] irq_stat;
  logic [5:0] irq_en;
  logic [5:0] irq_clr;
  logic [31:0] rd_mux;

  assign irq_clr = (wr_acc && avs_address == `CSP_REG_IRQ_CLR) ? avs_writedata[5:0] : 6'h00;

  always_comb
  begin
    if (avs_address == `CSP_REG_CTRL)
      rd_mux = {16'h0000, ctrl_reg};
    else if (avs_address == `CSP_REG_STATUS)
      rd_mux = {16'h0000, 3'h0, line_cnt, sel, reader_control_out, !baud_ok, ascii_mode,
                seq_state != SQ_IDLE || tx_state != TX_IDLE};
    else if (avs_address == `CSP_REG_RXDATA)
      rd_mux = {23'h000000, line_cnt != 5'h00, line_mem[rd_ptr[3:0]]};
    else if (avs_address == `CSP_REG_IRQ_STAT)
      rd_mux = {26'h0000000, irq_stat};
    else if (avs_address == `CSP_REG_IRQ_EN)
      rd_mux = {26'h0000000, irq_en};
    else
      rd_mux = 32'h00000000;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end
    else
    begin
      avs_waitrequest <= 1'b1;
      if ((avs_read || avs_write) && avs_waitrequest &&
          !(avs_write && avs_address == `CSP_REG_TXDATA && sw_pend))
      begin
        avs_waitrequest <= 1'b0;
        // Read data holds until the next read answer
        if (avs_read)
          avs_readdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_reg <= `CSP_CTRL_RESET;
      irq_en <= 6'h00;
      irq_stat <= 6'h00;
      irq <= 1'b0;
    end
    else
    begin
      if (wr_acc && avs_address == `CSP_REG_CTRL)
        ctrl_reg <= {avs_writedata[15:8], 4'h0, avs_writedata[3:0]};
      if (wr_acc && avs_address == `CSP_REG_IRQ_EN)
        irq_en <= avs_writedata[5:0];
      irq_stat <= (irq_stat & ~irq_clr) | {ev_rx[4], ev_txd, ev_rx[3:0]}; // see RULE8
      irq <= |(irq_stat & irq_en);
    end
  end

endmodule

`default_nettype wire

// file: testbench/csp_top_monitor.sv
// Port checker for the console serial port top, bound into csp_top.
// Assumes one clock domain and the active-low asynchronous reset.
`timescale 1ns/100ps
`default_nettype none
module csp_top_monitor (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic irq,
  input wire logic [3:0] baud_sel,
  input wire logic txd,
  input wire logic rts,
  input wire logic cts,
  input wire logic dsr,
  input wire logic dtr,
  input wire logic reader_control_out
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!resetn);
  logic rx_pop;
  logic [2:0] hold_cnt;
  assign rx_pop = avs_read & !avs_waitrequest & (avs_address == 5'h08);
  // Seven quiet cycles leave room for the input synchronisers
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      hold_cnt <= 3'h0;
    else if (baud_sel > 4'h2 && cts && dsr && dtr)
      hold_cnt <= 3'h0;
    else if (hold_cnt != 3'h7)
      hold_cnt <= hold_cnt + 3'h1;
  a_wait_one: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
    else $error("long answer");
  a_wait_cause: assert property ($fell(avs_waitrequest) |-> $past(avs_read) || $past(avs_write))
    else $error("answer without request");
  a_read_answer: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
    else $error("late read answer");
  a_rdata_hold: assert property (!$stable(avs_readdata) |-> avs_read && !avs_waitrequest)
    else $error("read data moved");
  a_irq_fall: assert property ($fell(irq) |-> $past(avs_write) || $past(avs_write, 2) || $past(avs_write, 3))
    else $error("irq fell unasked");
  a_reset_state: assert property ($rose(resetn) |-> avs_waitrequest && txd && !rts && !irq
    && !reader_control_out && avs_readdata == 32'h0)
    else $error("bad reset outputs");
  a_quiet_line: assert property (hold_cnt == 3'h7 && txd |=> txd)
    else $error("blocked frame");
  a_reader_pop: assert property ($rose(reader_control_out) |-> $past(rx_pop) || $past(rx_pop, 2))
    else $error("reader unasked");
  a_bit_width: assert property (!$stable(txd) |=> $stable(txd) [*7])
    else $error("short bit");
  cover property (rx_pop);
  cover property ($rose(irq));
  cover property ($rose(reader_control_out));
endmodule
bind csp_top csp_top_monitor csp_top_monitor_i (.*);
`default_nettype wire

// file: testbench/csp_term.sv
// Terminal model: decodes frames from txd and sends frames on rxd.
// Assumes the bench sets cyc to cycles per bit.
`timescale 1ns/100ps
`default_nettype none
module csp_term (
  input wire logic clk,
  input wire logic txd,
  input wire logic rts,
  output logic rxd
);
  int cyc = 16;
  int now = 0;
  logic [7:0] got_q[$];
  int st_q[$];
  always @(posedge clk)
    now <= now + 1;
  initial
  begin
    logic [7:0] b;
    rxd = 1'b1;
    forever
    begin
      @(negedge txd);
      st_q.push_back(now);
      repeat (cyc / 2) @(posedge clk);
      for (int i = 0; i < 8; i++)
      begin
        repeat (cyc) @(posedge clk);
        b[i] = txd;
      end
      repeat (cyc) @(posedge clk);
      // Low stop bit: frame dropped
      if (txd === 1'b1)
        got_q.push_back(b);
    end
  end
  task automatic send(input logic [7:0] c, input int stops);
    while (rts !== 1'b1)
      @(posedge clk);
    rxd <= 1'b0;
    repeat (cyc) @(posedge clk);
    for (int i = 0; i < 8; i++)
    begin
      rxd <= c[i];
      repeat (cyc) @(posedge clk);
    end
    rxd <= 1'b1;
    repeat (cyc * stops) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// file: testbench/tb_csp_top.sv
// Bench for the console serial port, one task per scenario.
// Assumes csp_term on the serial side and the bound port checker.
`timescale 1ns/100ps
`default_nettype none
module tb_csp_top
  import csp_pkg::*;
;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, irq, txd, rts, rxd, reader_control_out;
  logic [3:0] baud_sel = 4'h3;
  logic binary_format_strap = 1'b1;
  logic cts = 1'b1, dsr = 1'b1, dtr = 1'b1;
  int error_cnt = 0;
  int total_checks = 0;
  logic [31:0] r;
  csp_char_t eq[$];
  always #25 clk = ~clk;
  csp_top #(.BIT_CYC_A(16), .BIT_CYC_B(20), .BIT_CYC_C(24), .BIT_CYC_D(28), .BIT_CYC_E(32), .BIT_CYC_F(40))
  csp_top_i (.*);
  csp_term csp_term_i (.*);
  task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // One access, then an idle edge
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk);
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  function automatic csp_char_t ap(input csp_char_t c);
    return {^c[6:0], c[6:0]};
  endfunction
  task automatic sel(input int p, input int c);
    baud_sel <= 4'(p);
    csp_term_i.cyc = c;
    repeat (8) @(posedge clk);
    csp_term_i.st_q.delete();
  endtask
  // Waits for eq, then one frame more for extras
  task automatic expect_tx();
    for (int i = 0; i < 30000 && csp_term_i.got_q.size() < eq.size(); i++)
      @(posedge clk);
    repeat (12 * csp_term_i.cyc) @(posedge clk);
    chk("tx count", csp_term_i.got_q.size(), eq.size());
    foreach (eq[i])
      if (i < csp_term_i.got_q.size())
        chk("tx char", csp_term_i.got_q[i], eq[i]);
    csp_term_i.got_q.delete();
    eq.delete();
  endtask
  task automatic t_regs();
    bus(1'b0, 5'h00, 32'h0);
    chk("ctrl reset", r, 32'h1300);
    bus(1'b1, 5'h1C, 32'hFFFFFFFF);
    bus(1'b0, 5'h1C, 32'h0);
    chk("unmapped", r, 32'h0);
    bus(1'b0, 5'h00, 32'h0);
    chk("ctrl kept", r, 32'h1300);
    $display("done regs");
  endtask
  task automatic t_fill();
    for (int k = 0; k < 5; k++)
    begin
      if (k == 4)
        sel(9, 40);
      bus(1'b1, 5'h00, k < 4 ? 32'h1301 | (k << 1) : 32'h0001);
      bus(1'b1, 5'h0C, 32'h0D);
      eq = '{ap(8'h0D), ap(8'h0A)};
      if (k < 4)
        eq.push_back(ap(8'h13));
      repeat (k < 4 ? 4 - k : 4)
        eq.push_back(8'h00);
      expect_tx();
    end
    bus(1'b0, 5'h04, 32'h0);
    chk("ascii at 110", r[1], 1'b1);
    sel(3, 16);
    $display("done fill");
  endtask
  task automatic t_binary();
    binary_format_strap <= 1'b0;
    repeat (4) @(posedge clk);
    bus(1'b1, 5'h00, 32'h1301);
    bus(1'b1, 5'h0C, 32'h0D);
    eq = '{8'h0D};
    expect_tx();
    bus(1'b0, 5'h04, 32'h0);
    chk("ascii off", r[1], 1'b0);
    binary_format_strap <= 1'b1;
    $display("done binary");
  endtask
  task automatic t_frame();
    int cy[7] = '{16, 20, 24, 28, 32, 40, 40};
    int d;
    bus(1'b1, 5'h00, 32'h1300);
    for (int p = 3; p < 10; p++)
    begin
      sel(p, cy[p - 3]);
      bus(1'b1, 5'h0C, 32'h55);
      bus(1'b1, 5'h0C, 32'hAA);
      eq = '{8'h55, 8'hAA};
      expect_tx();
      d = csp_term_i.st_q[1] - csp_term_i.st_q[0] - cy[p - 3] * (p > 7 ? 11 : 10);
      chk("frame span", d > -2 && d < 8, 1'b1);
    end
    sel(3, 16);
    $display("done frame");
  endtask
  task automatic t_invalid();
    sel(1, 16);
    bus(1'b1, 5'h0C, 32'h55);
    repeat (400) @(posedge clk);
    chk("idle link", csp_term_i.got_q.size(), 0);
    bus(1'b0, 5'h04, 32'h0);
    chk("baud invalid", r[2], 1'b1);
    sel(3, 16);
    repeat (400) @(posedge clk);
    csp_term_i.got_q.delete();
    $display("done invalid");
  endtask
  task automatic t_modem();
    for (int i = 0; i < 3; i++)
    begin
      {cts, dsr, dtr} <= ~(3'h1 << i);
      bus(1'b1, 5'h0C, 32'h5A);
      repeat (400) @(posedge clk);
      chk("held", csp_term_i.got_q.size(), 0);
      {cts, dsr, dtr} <= 3'h7;
      eq = '{8'h5A};
      expect_tx();
    end
    $display("done modem");
  endtask
  task automatic t_rx();
    bus(1'b1, 5'h00, 32'h1301);
    bus(1'b1, 5'h18, 32'h3F);
    csp_term_i.send(8'h41, 1);
    csp_term_i.send(8'h42, 1);
    repeat (400) @(posedge clk);
    csp_term_i.got_q.delete();
    bus(1'b0, 5'h04, 32'h0);
    chk("line count", r[12:8], 5'h02);
    csp_term_i.send(8'h08, 1);
    eq = '{ap(8'h08)};
    expect_tx();
    bus(1'b0, 5'h04, 32'h0);
    chk("line count", r[12:8], 5'h01);
    csp_term_i.send(8'h7F, 1);
    eq = '{ap(8'h7F)};
    expect_tx();
    bus(1'b0, 5'h04, 32'h0);
    chk("line count", r[12:8], 5'h00);
    bus(1'b1, 5'h14, 32'h3F);
    bus(1'b0, 5'h10, 32'h0);
    chk("irq status", r, 32'h0);
    chk("irq low", irq, 1'b0);
    for (int e = 0; e < 2; e++)
    begin
      csp_term_i.send(e ? 8'h1B : 8'h0D, 1);
      eq = '{ap(8'h0D), ap(8'h0A), ap(8'h13), 8'h00, 8'h00, 8'h00};
      expect_tx();
      bus(1'b0, 5'h10, 32'h0);
      chk("brk eol", r[2:1], {e[0], 1'b1});
      chk("irq high", irq, 1'b1);
      bus(1'b1, 5'h18, 32'h0);
      repeat (2) @(posedge clk);
      chk("irq masked", irq, 1'b0);
      bus(1'b1, 5'h14, 32'h3F);
      bus(1'b1, 5'h18, 32'h3F);
    end
    $display("done rx");
  endtask
  task automatic t_reader();
    bus(1'b1, 5'h00, 32'h1300);
    for (int i = 0; i < 20; i++)
      bus(1'b0, 5'h08, 32'h0);
    csp_term_i.send(8'h41, 3);
    csp_term_i.send(8'h42, 1);
    repeat (400) @(posedge clk);
    bus(1'b0, 5'h08, 32'h0);
    chk("extra stops", r[8:0], 9'h141);
    bus(1'b0, 5'h08, 32'h0);
    chk("next char", r[8:0], 9'h142);
    bus(1'b0, 5'h10, 32'h0);
    chk("no framing", r[5], 1'b0);
    bus(1'b1, 5'h00, 32'h1309);
    csp_term_i.got_q.delete();
    csp_term_i.send(8'h43, 1);
    repeat (400) @(posedge clk);
    bus(1'b0, 5'h08, 32'h0);
    chk("reader data", r[8:0], 9'h143);
    repeat (2) @(posedge clk);
    chk("reader on", reader_control_out, 1'b1);
    eq = '{8'h11};
    expect_tx();
    csp_term_i.send(8'h0D, 1);
    eq = '{ap(8'h0D), ap(8'h0A), ap(8'h13), 8'h00, 8'h00, 8'h00};
    expect_tx();
    $display("done reader");
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    t_regs();
    t_fill();
    t_binary();
    t_frame();
    t_invalid();
    t_modem();
    t_rx();
    t_reader();
    close_out();
  end
  initial
  begin
    repeat (90000) @(posedge clk);
    error_cnt++;
    close_out();
  end
endmodule
`default_nettype wire
